// [verilog/dbp_brake_pid.sv]
// dc injection brake sequencer, resistor watch and process error
`timescale 1ns/10ps
`include "dbp_cfg.svh"
module dbp_brake_pid #(
	parameter int TICK_CYC = `DBP_TICK_NS / `DBP_CLK_NS
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [`DBP_AW-1:0] addr,
	input wire dbp_pkg::dbp_word_t wdata,
	input wire logic wr,
	input wire logic rd,
	output dbp_pkg::dbp_word_t rdata,
	input wire dbp_pkg::dbp_drv_s drv,
	output dbp_pkg::dbp_out_s out,
	output logic irq
);
	import dbp_pkg::*;

	dbp_st_s r, n;
	logic tick;
	logic [`DBP_IW-1:0] ev;
	logic en_stop, en_rev, en_start, lt_trig, brk, div_done;
	logic [1:0] ptype;
	dbp_word_t sp, div_q, climu;
	logic [31:0] vlim, hlim, clim32;
	logic [32:0] hsum;
	logic signed [16:0] pe_f;
	logic signed [17:0] clim;
	logic div_go;

	// register read mux, unmapped addresses read zero
	function automatic dbp_word_t reg_read(input logic [`DBP_AW-1:0] a, input dbp_st_s s);
		case (a)
		`DBP_A_CTRL: reg_read = s.cfg.ctrl;
		`DBP_A_TRIG: reg_read = s.cfg.trig;
		`DBP_A_STOPT: reg_read = s.cfg.stop_t;
		`DBP_A_STARTT: reg_read = s.cfg.start_t;
		`DBP_A_VOLTS: reg_read = s.cfg.volts;
		`DBP_A_VMAX: reg_read = s.cfg.vmax;
		`DBP_A_SPCMD: reg_read = s.cfg.sp_cmd;
		`DBP_A_ADJ: reg_read = s.cfg.adj;
		`DBP_A_WATTS: reg_read = s.cfg.watts;
		`DBP_A_TC: reg_read = s.cfg.tc;
		`DBP_A_STAT: reg_read = {6'h00, s.o.dir, s.fault, s.st};
		`DBP_A_ISTAT: reg_read = {13'h0000, s.istat};
		`DBP_A_IEN: reg_read = {13'h0000, s.ien};
		`DBP_A_PE: reg_read = s.o.process_error_value[15:0];
		default: reg_read = '0;
		endcase
	endfunction

	// the divide starts in the deciding cycle, so it scales by the frequency that set it off
	dbp_div u_div (
		.clock(clock),
		.rst_n(rst_n),
		.ce(ce),
		.go(div_go),
		.num(32'(r.cfg.stop_t) * 32'(drv.freq)),
		.den(r.cfg.trig),
		.done(div_done),
		.quo(div_q)
	);

	// static decodes of the configuration and drive inputs
	assign en_stop = r.cfg.ctrl[`DBP_C_STOP];
	assign en_rev = r.cfg.ctrl[`DBP_C_REV];
	assign en_start = r.cfg.ctrl[`DBP_C_START];
	assign ptype = r.cfg.ctrl[`DBP_C_PT_HI:`DBP_C_PT_LO];
	assign lt_trig = drv.freq < r.cfg.trig;
	assign vlim = 32'(r.cfg.vmax) * `DBP_SQ2_NUM / `DBP_SQ2_DEN;
	assign hlim = 32'(r.cfg.watts) * 32'(r.cfg.tc);
	assign clim32 = 32'(drv.speed) * 32'(r.cfg.adj) / `DBP_PCT_FULL;
	assign climu = (|clim32[31:16]) ? 16'hFFFF : clim32[15:0];
	assign clim = $signed({2'b00, climu});
	assign sp = r.cfg.ctrl[`DBP_C_SPFIX] ? r.cfg.sp_cmd : drv.sp_in;
	assign pe_f = $signed({1'b0, sp}) - $signed({1'b0, drv.fb});
	assign hsum = 33'(r.heat) + 33'(drv.power - r.cfg.watts);

	// next state of the whole block
	always_comb begin
		n = r;
		ev = '0;
		n.rdata = '0;
		div_go = 1'b0;
		tick = (r.tick == `DBP_TW'(TICK_CYC - 1));
		n.tick = tick ? '0 : r.tick + 15'h0001;

		// software writes; clearing the fault status also clears the latch
		if (wr) begin
			case (addr)
			`DBP_A_CTRL: n.cfg.ctrl = wdata;
			`DBP_A_TRIG: n.cfg.trig = wdata;
			`DBP_A_STOPT: n.cfg.stop_t = wdata;
			`DBP_A_STARTT: n.cfg.start_t = wdata;
			`DBP_A_VOLTS: n.cfg.volts = wdata;
			`DBP_A_VMAX: n.cfg.vmax = wdata;
			`DBP_A_SPCMD: n.cfg.sp_cmd = wdata;
			`DBP_A_ADJ: n.cfg.adj = wdata;
			`DBP_A_WATTS: n.cfg.watts = wdata;
			`DBP_A_TC: n.cfg.tc = wdata;
			`DBP_A_IEN: n.ien = wdata[`DBP_IW-1:0];
			`DBP_A_ICLR: begin
				n.istat = r.istat & ~wdata[`DBP_IW-1:0];
				if (wdata[`DBP_I_FLT]) n.fault = 1'b0;
			end
			default: ;
			endcase
		end
		if (rd) n.rdata = reg_read(addr, r);

		// brake sequencer
		unique case (r.st)
		ST_IDLE: if (drv.run) begin
			n.o.dir = drv.dir;
			if (en_start) begin
				n.st = ST_SBRK;
				n.timer = r.cfg.start_t;
				ev[`DBP_I_BON] = 1'b1;
			end else begin
				n.st = ST_RUN;
			end
		end
		ST_SBRK: if (!drv.run || drv.stop) begin
			n.st = ST_IDLE;
			ev[`DBP_I_BOFF] = 1'b1;
		end else if (tick) begin
			if (r.timer == '0) begin
				n.st = ST_RUN;
				ev[`DBP_I_BOFF] = 1'b1;
			end else begin
				n.timer = r.timer - 16'h0001;
			end
		end
		ST_RUN: if (drv.stop) begin
			n.st = en_stop ? ST_DEC : ST_IDLE;
		end else if (drv.dir != r.o.dir) begin
			if (en_rev) n.st = ST_RDEC;
			else n.o.dir = drv.dir;
		end
		ST_DEC: if (drv.freq <= r.cfg.trig) begin
			ev[`DBP_I_BON] = 1'b1;
			if (lt_trig) begin
				n.st = ST_CALC;
				div_go = 1'b1;
			end else begin
				n.st = ST_PBRK;
				n.timer = r.cfg.stop_t;
			end
		end
		ST_CALC: if (div_done) begin
			n.st = ST_PBRK;
			n.timer = div_q;
		end
		// stop time is an upper bound; the braking ends at zero
		ST_PBRK: if (tick) begin
			if (r.timer == '0) begin
				n.st = ST_IDLE;
				ev[`DBP_I_BOFF] = 1'b1;
			end else begin
				n.timer = r.timer - 16'h0001;
			end
		end
		ST_RDEC: if (drv.freq <= r.cfg.trig) begin
			n.st = ST_RBRK;
			ev[`DBP_I_BON] = 1'b1;
		end
		ST_RBRK: if (drv.stopped) begin
			n.st = ST_RUN;
			n.o.dir = ~r.o.dir;
			ev[`DBP_I_BOFF] = 1'b1;
		end
		endcase

		// resistor heat: excess over rating adds, margin below it cools
		if (tick) begin
			if (drv.power > r.cfg.watts) begin
				n.heat = (hsum > 33'(hlim)) ? hlim : hsum[31:0];
			end else begin
				n.heat = (r.heat > 32'(r.cfg.watts - drv.power)) ?
					r.heat - 32'(r.cfg.watts - drv.power) : '0;
			end
		end
		if (hlim != '0 && n.heat >= hlim && !n.fault) begin
			n.fault = 1'b1;
			ev[`DBP_I_FLT] = 1'b1;
		end
		n.istat = n.istat | ev; // a new event beats a clear in the same cycle

		// registered outputs; enables come from the updated config
		brk = (n.st == ST_SBRK) || (n.st == ST_PBRK) || (n.st == ST_RBRK);
		n.o.inject = brk && (|n.cfg.ctrl[`DBP_C_START:`DBP_C_STOP]);
		n.o.volts = n.o.inject ? ((32'(r.cfg.volts) > vlim) ? vlim[15:0] : r.cfg.volts) :
			'0;
		n.o.accel = (n.st == ST_RUN);
		n.o.fault = n.fault;
		n.o.ff_en = 1'b1;

		// process error and limited correction
		case (ptype)
		`DBP_PT_FWD: begin
			n.o.pid_en = 1'b1;
			n.o.process_error_value = pe_f;
		end
		`DBP_PT_REV: begin
			n.o.pid_en = 1'b1;
			n.o.process_error_value = -pe_f;
		end
		default: begin
			n.o.pid_en = 1'b0;
			n.o.process_error_value = '0;
		end
		endcase
		if (18'(n.o.process_error_value) > clim) n.o.corr = 17'(clim);
		else if (18'(n.o.process_error_value) < -clim) n.o.corr = 17'(-clim);
		else n.o.corr = n.o.process_error_value;
	end

	// one register for the whole state; low ce freezes everything
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
			r.st <= ST_IDLE;
			r.cfg.ctrl <= `DBP_RST_W;
			r.o.ff_en <= 1'b1; // feedforward stays available, even in reset
		end else if (ce) begin
			r <= n;
		end
	end

	assign rdata = r.rdata;
	assign out = r.o;
	assign irq = |(r.istat & r.ien);

	// checks; timed ones assume ce stays high
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence s_late_brake;
		ce && r.st == ST_DEC && lt_trig;
	endsequence
	sequence s_calc_then_brake;
		r.st == ST_CALC ##[1:40] r.st == ST_PBRK && r.o.inject;
	endsequence

	property p_vlim;
		ce |=> 32'(r.o.volts) <= $past(vlim);
	endproperty
	a_vlim: assert property (p_vlim) else $error("brake volts above ceiling");

	property p_no_en;
		r.o.inject |-> (|r.cfg.ctrl[`DBP_C_START:`DBP_C_STOP]);
	endproperty
	a_no_en: assert property (p_no_en) else $error("inject with no enable");

	property p_direct_run;
		ce && r.st == ST_IDLE && drv.run && !en_start |=> r.st == ST_RUN && r.o.accel;
	endproperty
	a_direct_run: assert property (p_direct_run) else $error("run not direct");

	property p_start_brk;
		ce && r.st == ST_IDLE && drv.run && en_start |=> r.o.inject && !r.o.accel;
	endproperty
	a_start_brk: assert property (p_start_brk) else $error("no start brake");

	property p_trig;
		ce && r.st == ST_DEC && drv.freq == r.cfg.trig |=> r.st == ST_PBRK
			&& r.timer == $past(r.cfg.stop_t) && r.o.inject;
	endproperty
	a_trig: assert property (p_trig) else $error("stop brake not at trigger");

	property p_short;
		s_late_brake |=> s_calc_then_brake;
	endproperty
	a_short: assert property (p_short) else $error("short brake not timed");

	property p_q;
		ce && r.st == ST_CALC && div_done |=> r.timer == $past(div_q);
	endproperty
	a_q: assert property (p_q) else $error("short time not loaded");

	property p_stop_end;
		ce && tick && r.st == ST_PBRK && r.timer == '0 |=> r.st == ST_IDLE && !r.o.inject;
	endproperty
	a_stop_end: assert property (p_stop_end) else $error("stop brake overran");

	property p_rev;
		ce && r.st == ST_RBRK && drv.stopped |=> r.o.accel && r.o.dir != $past(r.o.dir);
	endproperty
	a_rev: assert property (p_rev) else $error("reverse did not follow");

	property p_none;
		ce && ptype == `DBP_PT_NONE |=> !r.o.pid_en && r.o.ff_en;
	endproperty
	a_none: assert property (p_none) else $error("pid not off for none");

	property p_rev_pe;
		ce && ptype == `DBP_PT_REV |=> r.o.process_error_value == -$past(pe_f);
	endproperty
	a_rev_pe: assert property (p_rev_pe) else $error("reverse error wrong");

	property p_fix_pe;
		ce && ptype == `DBP_PT_FWD && r.cfg.ctrl[`DBP_C_SPFIX] |=>
			r.o.process_error_value == $past($signed({1'b0, r.cfg.sp_cmd})
			- $signed({1'b0, drv.fb}));
	endproperty
	a_fix_pe: assert property (p_fix_pe) else $error("fixed setpoint unused");

	property p_clamp;
		ce |=> 18'(r.o.corr) <= $past(clim) && 18'(r.o.corr) >= -$past(clim);
	endproperty
	a_clamp: assert property (p_clamp) else $error("correction over limit");

	property p_fault;
		ce && hlim != '0 && n.heat >= hlim |=> r.o.fault;
	endproperty
	a_fault: assert property (p_fault) else $error("regen fault missed");

	property p_fwd_pe;
		ce && ptype == `DBP_PT_FWD |=> r.o.process_error_value == $past(pe_f);
	endproperty
	a_fwd_pe: assert property (p_fwd_pe) else $error("forward error wrong");

	property p_stop_go;
		ce && r.st == ST_RUN && drv.stop && en_stop |=> r.st == ST_DEC && !r.o.accel
			&& !r.o.inject;
	endproperty
	a_stop_go: assert property (p_stop_go) else $error("stop did not decelerate");

	property p_rev_dir;
		ce && r.st == ST_RUN && !drv.stop && en_rev && drv.dir != r.o.dir |=>
			r.st == ST_RDEC && !r.o.accel;
	endproperty
	a_rev_dir: assert property (p_rev_dir) else $error("reverse did not decelerate");

	property p_start_end;
		ce && tick && r.st == ST_SBRK && r.timer == '0 && drv.run && !drv.stop |=>
			r.o.accel && !r.o.inject;
	endproperty
	a_start_end: assert property (p_start_end) else $error("start brake not released");

	property p_rd_idle;
		ce && !rd |=> rdata == '0;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not cleared");

	// a low enable must hold every bit of state, tick and read data too
	property p_freeze;
		!ce |=> $stable(r);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved with enable low");
endmodule // dbp_brake_pid

// [verilog/dbp_cfg.svh]
// constants for the dc brake sequencer and process error block
//
// How it works
// - regen fault: 2x watts in TC, 3x in TC/2
// - brake volts capped at 1.414 times max volts
// - stop braking starts at trigger frequency
// - stop brake time is a maximum, then off
// - late start shortens time by freq over trigger
// - reverse: brake until stopped, then reverse
// - start braking for start time, then accelerate
// - no start braking unless enabled
// - type none disables pid, keeps feedforward
// - forward acting error is setpoint minus feedback
// - reverse acting error is feedback minus setpoint
// - speed correction clamped to percent of speed
// - fixed setpoint source uses setpoint command register
`ifndef DBP_CFG_SVH
`define DBP_CFG_SVH

`define DBP_AW 8
`define DBP_DW 16
`define DBP_TW 15
`define DBP_IW 3

// register byte addresses
`define DBP_A_CTRL 8'h00
`define DBP_A_TRIG 8'h04
`define DBP_A_STOPT 8'h08
`define DBP_A_STARTT 8'h0C
`define DBP_A_VOLTS 8'h10
`define DBP_A_VMAX 8'h14
`define DBP_A_SPCMD 8'h18
`define DBP_A_ADJ 8'h1C
`define DBP_A_WATTS 8'h20
`define DBP_A_TC 8'h24
`define DBP_A_STAT 8'h28
`define DBP_A_ISTAT 8'h2C
`define DBP_A_IEN 8'h30
`define DBP_A_ICLR 8'h34
`define DBP_A_PE 8'h38

// control register fields
`define DBP_C_STOP 0
`define DBP_C_REV 1
`define DBP_C_START 2
`define DBP_C_PT_LO 3
`define DBP_C_PT_HI 4
`define DBP_C_SPFIX 5
`define DBP_PT_NONE 2'h0
`define DBP_PT_FWD 2'h1
`define DBP_PT_REV 2'h2

// interrupt status bits
`define DBP_I_BON 0
`define DBP_I_BOFF 1
`define DBP_I_FLT 2

`define DBP_RST_W 16'h0000

// timing: brake times and thermal constant count in 1 ms ticks
`define DBP_CLK_NS 50
`define DBP_TICK_NS 1000000

// brake voltage ceiling factor 1.414 as a ratio
`define DBP_SQ2_NUM 32'h0000_0586
`define DBP_SQ2_DEN 32'h0000_03E8
`define DBP_PCT_FULL 32'h0000_0064

`define DBP_DIV_STEPS 6'h20

`endif

// [verilog/dbp_pkg.sv]
// types shared by the dc brake sequencer and its divider
package dbp_pkg;
`include "dbp_cfg.svh"

	typedef logic [`DBP_DW-1:0] dbp_word_t;

	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_SBRK = 8'h02,
		ST_RUN = 8'h04,
		ST_DEC = 8'h08,
		ST_CALC = 8'h10,
		ST_PBRK = 8'h20,
		ST_RDEC = 8'h40,
		ST_RBRK = 8'h80
	} dbp_state_e;

	// drive-side inputs, all on the block clock
	typedef struct packed {
		dbp_word_t freq;
		logic run;
		logic stop;
		logic dir;
		logic stopped;
		dbp_word_t power;
		dbp_word_t fb;
		dbp_word_t sp_in;
		dbp_word_t speed;
	} dbp_drv_s;

	typedef struct packed {
		logic inject;
		dbp_word_t volts;
		logic accel;
		logic dir;
		logic pid_en;
		logic ff_en;
		logic signed [16:0] process_error_value;
		logic signed [16:0] corr;
		logic fault;
	} dbp_out_s;

	typedef struct packed {
		dbp_word_t ctrl;
		dbp_word_t trig;
		dbp_word_t stop_t;
		dbp_word_t start_t;
		dbp_word_t volts;
		dbp_word_t vmax;
		dbp_word_t sp_cmd;
		dbp_word_t adj;
		dbp_word_t watts;
		dbp_word_t tc;
	} dbp_cfg_s;

	typedef struct packed {
		dbp_state_e st;
		dbp_word_t timer;
		logic [31:0] heat;
		logic fault;
		logic [`DBP_IW-1:0] istat;
		logic [`DBP_IW-1:0] ien;
		dbp_cfg_s cfg;
		dbp_word_t rdata;
		logic [`DBP_TW-1:0] tick;
		dbp_out_s o;
	} dbp_st_s;

	typedef struct packed {
		logic busy;
		logic done;
		logic [5:0] cnt;
		logic [16:0] rem;
		logic [31:0] q;
	} dbp_div_s;
endpackage

// [verilog/dbp_div.sv]
// serial restoring divider for the shortened stop brake time
`timescale 1ns/10ps
`include "dbp_cfg.svh"
module dbp_div (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic go,
	input wire logic [31:0] num,
	input wire dbp_pkg::dbp_word_t den,
	output logic done,
	output dbp_pkg::dbp_word_t quo
);
	import dbp_pkg::*;

	dbp_div_s r, n;
	logic [16:0] trial;

	// one quotient bit per cycle; slow but small, and the brake waits
	always_comb begin
		n = r;
		n.done = 1'b0;
		trial = {r.rem[15:0], r.q[31]};
		if (go) begin
			n.busy = 1'b1;
			n.cnt = `DBP_DIV_STEPS;
			n.rem = '0;
			n.q = num;
		end else if (r.busy) begin
			n.cnt = r.cnt - 6'h01;
			if (trial >= {1'b0, den}) begin
				n.rem = trial - {1'b0, den};
				n.q = {r.q[30:0], 1'b1};
			end else begin
				n.rem = trial;
				n.q = {r.q[30:0], 1'b0};
			end
			if (r.cnt == 6'h01) begin
				n.busy = 1'b0;
				n.done = 1'b1;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) r <= '0;
		else if (ce) r <= n;
	end

	assign done = r.done;
	assign quo = r.q[15:0]; // quotient never exceeds the stop time
endmodule // dbp_div

// [testbench/dbp_motor.sv]
// behavioural motor: output frequency ramp and standstill flag
`timescale 1ns/10ps
module dbp_motor (
	input wire logic clock,
	input wire logic rst_n,
	input wire dbp_pkg::dbp_out_s out,
	input wire dbp_pkg::dbp_word_t top,
	output dbp_pkg::dbp_word_t freq,
	output logic stopped
);
	import dbp_pkg::*;
	// ramps up to top while accel is allowed, else coasts down one step a cycle
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			freq <= 16'h0000;
		end else if (out.accel && freq < top) begin
			freq <= freq + 16'h0001;
		end else if (!out.accel && freq != 16'h0000) begin
			freq <= freq - 16'h0001;
		end
	end
	// standstill is judged from frequency alone, no slip modelled
	assign stopped = (freq == 16'h0000);
endmodule // dbp_motor

// [testbench/test_dbp_brake_pid.sv]
// self-checking bench for the dc brake sequencer and process error block
`timescale 1ns/10ps
`include "dbp_cfg.svh"
module test_dbp_brake_pid;
	import dbp_pkg::*;
	logic clock = 0;
	logic rst_n = 0;
	logic [7:0] addr = 8'h00;
	logic wr = 0;
	logic rd = 0;
	logic rd_q = 0;
	logic run = 0;
	logic stop = 0;
	logic dir = 0;
	logic noinj = 0;
	logic ce = 1;
	logic stopped;
	logic irq;
	dbp_word_t wdata = 16'h0000, power = 16'h0000, fb = 16'h0000, sp = 16'h0000;
	dbp_word_t top = 16'h0028, spc, rdata, freq;
	dbp_drv_s drv;
	dbp_out_s out;
	dbp_word_t exp_q[$];
	int err_count = 0, comparisons = 0, n;
	logic signed [16:0] pe, lim;
	assign drv = '{freq: freq, run: run, stop: stop, dir: dir, stopped: stopped,
		power: power, fb: fb, sp_in: sp, speed: 16'h03E8};
	always #25 clock = ~clock;
	dbp_brake_pid #(.TICK_CYC(4)) i_dut (.clock(clock), .rst_n(rst_n), .ce(ce),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .drv(drv),
		.out(out), .irq(irq));
	dbp_motor i_motor (.clock(clock), .rst_n(rst_n), .out(out), .top(top),
		.freq(freq), .stopped(stopped));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// each bus task starts on a fresh edge so a strobe is never set twice at once
	task automatic wreg(input logic [7:0] a, input dbp_word_t d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input dbp_word_t e);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge clock);
		rd <= 1'b0;
	endtask
	function automatic logic hit(input int s);
		case (s)
			0: return out.inject === 1'b1;
			1: return out.inject === 1'b0;
			2: return out.accel === 1'b1;
			default: return out.fault === 1'b1;
		endcase
	endfunction
	// bounded wait, sampled at the falling edge where outputs have settled
	task automatic wt(input int s, output int c);
		c = 0;
		while (!hit(s) && c < 200) begin
			@(negedge clock);
			c++;
		end
	endtask
	task automatic go();
		@(posedge clock);
		run <= 1'b1;
		wt(2, n);
		repeat (50) @(posedge clock);
	endtask
	task automatic halt();
		@(posedge clock);
		run <= 1'b0;
		stop <= 1'b1;
		@(posedge clock);
		stop <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe, so compare there
	always @(posedge clock) begin
		rd_q <= rd;
		if (rd_q) begin
			chk(rdata, exp_q.pop_front(), "rdata");
		end
	end
	// with no brake enable the windings must stay unpowered throughout
	always @(negedge clock) begin
		if (noinj) begin
			chk(out.inject, 0, "inject");
		end
	end
	initial begin
		#1000000;
		err_count++;
		final_report();
	end
	initial begin
		void'($urandom(12542));
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		rchk(`DBP_A_CTRL, 16'h0000);
		rchk(`DBP_A_ISTAT, 16'h0000);
		wreg(`DBP_A_STAT, 16'hFFFF);
		rchk(`DBP_A_STAT, 16'h0001);
		rchk(8'h3C, 16'h0000);
		// every process type, live and fixed setpoint, small values to hit the clamp edge
		wreg(`DBP_A_ADJ, 16'h000A);
		for (int i = 0; i < 8; i++) begin
			spc = $urandom & 16'h00FF;
			fb <= $urandom & 16'h00FF;
			sp <= $urandom & 16'h00FF;
			wreg(`DBP_A_SPCMD, spc);
			wreg(`DBP_A_CTRL, 16'((i % 4) * 8 + (i / 4) * 32));
			repeat (3) @(negedge clock);
			pe = {1'b0, (i > 3) ? spc : sp} - {1'b0, fb};
			if (i % 4 == 2) pe = -pe;
			lim = (pe > 100) ? 17'sd100 : (pe < -100) ? -17'sd100 : pe;
			chk(out.pid_en, (i % 4 == 1 || i % 4 == 2), "pid_en");
			chk(out.ff_en, 1, "ff_en");
			if (i % 4 == 1 || i % 4 == 2) begin
				chk(out.process_error_value, pe, "pe");
				chk(out.corr, lim, "corr");
			end
		end
		wreg(`DBP_A_TRIG, 16'h0014);
		wreg(`DBP_A_STOPT, 16'h000A);
		wreg(`DBP_A_STARTT, 16'h0002);
		wreg(`DBP_A_VOLTS, 16'h03E8);
		wreg(`DBP_A_VMAX, 16'h0064);
		// a write strobed while the enable is low must be lost whole
		ce <= 1'b0;
		wreg(`DBP_A_TRIG, 16'h0063);
		ce <= 1'b1;
		rchk(`DBP_A_TRIG, 16'h0014);
		// run straight to acceleration with every enable off
		wreg(`DBP_A_CTRL, 16'h0000);
		noinj <= 1'b1;
		go();
		chk(n < 4, 1, "direct accel");
		halt();
		repeat (50) @(posedge clock);
		noinj <= 1'b0;
		// start braking, volts capped at 100 * 1.414
		wreg(`DBP_A_CTRL, 16'h0004);
		@(posedge clock);
		run <= 1'b1;
		wt(0, n);
		chk(n < 4, 1, "start brake");
		chk(out.volts, 16'h008D, "volts");
		wt(2, n);
		chk(n > 4 && n < 16, 1, "start span");
		chk(out.inject, 0, "released");
		halt();
		repeat (50) @(posedge clock);
		// stop braking from above the trigger: full time applies
		wreg(`DBP_A_CTRL, 16'h0001);
		go();
		halt();
		wt(0, n);
		chk(freq > 14 && freq < 21, 1, "trigger");
		wt(1, n);
		chk(n > 35 && n < 49, 1, "stop span");
		repeat (50) @(posedge clock);
		// stop from 6, below the trigger: 10 * 6 / 20 = 3 ticks, then the closing tick
		top <= 16'h0006;
		go();
		halt();
		wt(0, n);
		wt(1, n);
		chk(n > 12 && n < 17, 1, "short span");
		repeat (50) @(posedge clock);
		// reverse: brake until standstill, then run the other way
		top <= 16'h0028;
		wreg(`DBP_A_CTRL, 16'h0002);
		go();
		@(posedge clock);
		dir <= 1'b1;
		wt(0, n);
		chk(n < 60, 1, "rev brake");
		wt(2, n);
		chk(n > 10, 1, "brake to stop");
		chk(out.dir, 1, "new dir");
		halt();
		repeat (50) @(posedge clock);
		// resistor heat at 2x then 3x rating, with irq masked and cleared
		wreg(`DBP_A_WATTS, 16'h000A);
		wreg(`DBP_A_TC, 16'h0004);
		wreg(`DBP_A_ICLR, 16'h0007);
		wreg(`DBP_A_IEN, 16'h0004);
		@(posedge clock);
		power <= 16'h0014;
		wt(3, n);
		chk(n > 11 && n < 22, 1, "2x time");
		chk(irq, 1, "irq");
		rchk(`DBP_A_ISTAT, 16'h0004);
		wreg(`DBP_A_IEN, 16'h0000);
		@(negedge clock);
		chk(irq, 0, "masked");
		@(posedge clock);
		power <= 16'h0000;
		repeat (40) @(posedge clock);
		wreg(`DBP_A_ICLR, 16'h0007);
		rchk(`DBP_A_ISTAT, 16'h0000);
		@(posedge clock);
		power <= 16'h001E;
		wt(3, n);
		chk(n > 3 && n < 13, 1, "3x time");
		final_report();
	end
endmodule // test_dbp_brake_pid
